/* File: rtl/tsm_convert.sv */
// thermal sensor mode control: conversion sequencer
// assumes the adc words on raw are valid whenever sampled
module tsm_convert (
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire logic               standby,
	input  wire logic               one_shot,
	input  wire tsm_pkg::tsm_temps_t raw,
	output logic                    busy,
	output tsm_pkg::tsm_temps_t     result
);

	typedef struct packed {
		logic                busy;
		logic                stby_p;
		logic [15:0]         cnt;
		tsm_pkg::tsm_temps_t res;
	} tsm_conv_t;

	localparam logic [15:0] LAST = 16'(tsm_pkg::TSM_CONV_CYCLES - 1);

	tsm_conv_t s_q;
	tsm_conv_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.stby_p = standby;
		if (s_q.busy) begin
			if (s_q.cnt == LAST) begin
				s_d.res = raw;
				s_d.cnt = 16'h0000;
				s_d.busy = !standby;
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
		end
		if (standby && !s_q.stby_p) begin
			// abandon the cycle in flight; result keeps last value unless that cycle reaches LAST here
			s_d.busy = 1'b0;
			s_d.cnt = 16'h0000;
		end else if (!standby && !s_q.busy) begin
			s_d.busy = 1'b1;
		end else if (standby && one_shot && !s_q.busy) begin
			s_d.busy = 1'b1;
			s_d.cnt = 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign result = s_q.res;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_shot_req;
		standby && s_q.stby_p && one_shot && !s_q.busy;
	endsequence

	a_stop_at_once: assert property ($rose(standby) |=> !busy)
		else $error("conversion kept running after standby select");
	// the release edge is skipped: busy is still low there by design
	a_auto_running: assert property (!reset && !standby ##1 !standby |-> busy)
		else $error("no conversion while in auto mode");
	a_one_shot_run: assert property (s_shot_req |=> busy && s_q.cnt == 16'h0000)
		else $error("one-shot request did not start a conversion");
	a_shot_ends: assert property (busy && standby && s_q.stby_p && s_q.cnt == LAST
		|=> !busy && result == $past(raw))
		else $error("one-shot conversion did not end with a result");
	a_idle_standby: assert property (standby && s_q.stby_p && !busy && !one_shot |=> !busy)
		else $error("conversion started in standby without request");

endmodule

/* File: rtl/tsm_sensor.sv */
// thermal sensor mode control: smbus target, configuration, alert
// assumes smbus pins sampled synchronously, wired-and resolved outside
//
// Contract
// - target answers only at 7-bit address 1001110; host uses that address.
// - config bit 6 resets to 0; while 0, conversions run continuously.
// - writing bit 6 to 1 aborts the running conversion and enters standby.
// - in standby, a one-shot command performs one conversion; one sent while a conversion runs is ignored.
// - config bit 7 resets to 0; while 1, alert stays deasserted.
// - bits 5-0 reserved, reset 0; host writes zero, ignores on read.
// - alert asserts when either temperature lies outside the thresholds.
module tsm_sensor (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic                 smb_clk,
	input  wire logic                 smb_data,
	output logic                      smb_data_val,
	output logic                      smb_data_oe,
	output logic                      alert_n_val,
	output logic                      alert_n_oe,
	input  wire tsm_pkg::tsm_temps_t  raw_temps,
	input  wire tsm_pkg::tsm_limits_t limits,
	output tsm_pkg::tsm_temps_t       temps,
	output logic                      converting
);

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_AACK = 9'h004,
		S_CMD  = 9'h008,
		S_CACK = 9'h010,
		S_DATA = 9'h020,
		S_DACK = 9'h040,
		S_RD   = 9'h080,
		S_RACK = 9'h100
	} tsm_state_t;

	typedef struct packed {
		tsm_state_t  st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  cmd;
		logic        rw;
		logic [7:0]  cfg;
		logic        oe;
		logic        scl_p;
		logic        sda_p;
		logic        shot;
		logic        alert;
	} tsm_smb_t;

	tsm_smb_t            s_q;
	tsm_smb_t            s_d;
	tsm_pkg::tsm_temps_t res;
	logic                busy;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_ev;
	logic                stop_ev;
	logic                out_of_range;

	function automatic logic outside(input logic signed [7:0] t,
			input tsm_pkg::tsm_limits_t l);
		outside = (t > l.upper) || (t < l.lower);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus edge detection on synchronous samples

	assign scl_rise = smb_clk && !s_q.scl_p;
	assign scl_fall = !smb_clk && s_q.scl_p;
	assign start_ev = smb_clk && s_q.scl_p && s_q.sda_p && !smb_data;
	assign stop_ev  = smb_clk && s_q.scl_p && !s_q.sda_p && smb_data;

	assign out_of_range = outside(res.remote, limits) || outside(res.local_die, limits);

	////////////////////////////////////////////////////////////////////////
	// target state machine

	always_comb begin
		s_d = s_q;
		s_d.scl_p = smb_clk;
		s_d.sda_p = smb_data;
		s_d.shot = 1'b0;
		s_d.alert = out_of_range && !s_q.cfg[tsm_pkg::TSM_CFG_MASK_BIT];
		if (start_ev) begin
			s_d.st = S_ADDR;
			s_d.cnt = 4'h0;
			s_d.oe = 1'b0;
		end else if (stop_ev) begin
			s_d.st = S_IDLE;
			s_d.oe = 1'b0;
		end else if (scl_rise) begin
			if (s_q.st == S_ADDR || s_q.st == S_CMD || s_q.st == S_DATA) begin
				s_d.sh = {s_q.sh[6:0], smb_data};
				s_d.cnt = s_q.cnt + 4'h1;
			end else if (s_q.st == S_RD) begin
				s_d.cnt = s_q.cnt + 4'h1;
			end
		end else if (scl_fall) begin
			case (s_q.st)
				S_ADDR: begin
					if (s_q.cnt == 4'h8) begin
						if (s_q.sh[7:1] == tsm_pkg::TSM_SMB_ADDR) begin
							s_d.st = S_AACK;
							s_d.rw = s_q.sh[0];
							s_d.oe = 1'b1;
						end else begin
							s_d.st = S_IDLE;
						end
					end
				end
				S_AACK: begin
					s_d.cnt = 4'h0;
					if (s_q.rw) begin
						// reads return the configuration only after its command
						s_d.sh = (s_q.cmd == tsm_pkg::TSM_CMD_CONFIG) ? s_q.cfg : 8'h00;
						s_d.oe = (s_q.cmd == tsm_pkg::TSM_CMD_CONFIG) ? !s_q.cfg[7] : 1'b1;
						s_d.st = S_RD;
					end else begin
						s_d.oe = 1'b0;
						s_d.st = S_CMD;
					end
				end
				S_CMD: begin
					if (s_q.cnt == 4'h8) begin
						s_d.cmd = s_q.sh;
						s_d.oe = 1'b1;
						s_d.st = S_CACK;
						// request is dropped by the sequencer outside standby
						s_d.shot = (s_q.sh == tsm_pkg::TSM_CMD_ONESHOT);
					end
				end
				S_CACK: begin
					s_d.oe = 1'b0;
					s_d.cnt = 4'h0;
					s_d.st = S_DATA;
				end
				S_DATA: begin
					if (s_q.cnt == 4'h8) begin
						s_d.oe = 1'b1;
						s_d.st = S_DACK;
						if (s_q.cmd == tsm_pkg::TSM_CMD_CONFIG) begin
							s_d.cfg = s_q.sh & tsm_pkg::TSM_CFG_WR_MASK;
						end
					end
				end
				S_DACK: begin
					// further bytes go unacknowledged
					s_d.oe = 1'b0;
					s_d.st = S_IDLE;
				end
				S_RD: begin
					if (s_q.cnt == 4'h8) begin
						s_d.oe = 1'b0;
						s_d.st = S_RACK;
					end else begin
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.oe = !s_q.sh[6];
					end
				end
				S_RACK: begin
					s_d.st = S_IDLE;
				end
				S_IDLE: begin
					s_d.oe = 1'b0;
				end
				default: begin
					s_d.st = S_IDLE;
					s_d.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
			s_q.st <= S_IDLE;
			s_q.cfg <= tsm_pkg::TSM_CFG_RESET;
			s_q.scl_p <= 1'b1;
			s_q.sda_p <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	tsm_convert u_convert (
		.clock    (clock),
		.reset    (reset),
		.standby  (s_q.cfg[tsm_pkg::TSM_CFG_STBY_BIT]),
		.one_shot (s_q.shot),
		.raw      (raw_temps),
		.busy     (busy),
		.result   (res)
	);

	assign smb_data_val = 1'b0;
	assign smb_data_oe = s_q.oe;
	assign alert_n_val = 1'b0;
	assign alert_n_oe = s_q.alert;
	assign temps = res;
	assign converting = busy;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_addr_done;
		s_q.st == S_ADDR && scl_fall && !start_ev && !stop_ev && s_q.cnt == 4'h8;
	endsequence

	a_addr_match: assert property (s_addr_done |=>
		(s_q.st == S_AACK) == ($past(s_q.sh[7:1]) == tsm_pkg::TSM_SMB_ADDR))
		else $error("address acknowledge does not follow the fixed address");
	a_ack_drive: assert property (s_q.st == S_AACK |-> smb_data_oe)
		else $error("address acknowledge not driven");
	a_cfg_reset: assert property ($past(reset) |-> s_q.cfg == tsm_pkg::TSM_CFG_RESET)
		else $error("configuration not cleared by reset");
	a_reserved_zero: assert property (s_q.cfg[5:0] == 6'h00)
		else $error("reserved configuration bits hold ones");
	a_cfg_write: assert property (s_q.st == S_DATA && scl_fall && !start_ev && !stop_ev
		&& s_q.cnt == 4'h8 && s_q.cmd == tsm_pkg::TSM_CMD_CONFIG
		|=> s_q.cfg[7:6] == $past(s_q.sh[7:6]) ##1 s_q.cfg[7:6] == $past(s_q.sh[7:6], 2))
		else $error("write-byte did not update configuration");
	a_alert_mask: assert property (s_q.cfg[7] ##1 s_q.cfg[7] |-> !alert_n_oe)
		else $error("alert driven while masked");
	a_alert_range: assert property (!s_q.cfg[7] && out_of_range |=> alert_n_oe)
		else $error("alert not driven for out-of-range temperature");
	a_shot_pulse: assert property (s_q.shot |-> s_q.cmd == tsm_pkg::TSM_CMD_ONESHOT ##1 !s_q.shot)
		else $error("one-shot request without its command or longer than one cycle");

endmodule

/* File: shared/tsm_pkg.sv */
// thermal sensor mode control: constants, carrier types
// assumes a 200 MHz system clock and synchronous smbus pin samples
package tsm_pkg;

	localparam logic [6:0] TSM_SMB_ADDR    = 7'h4e;
	localparam logic [7:0] TSM_CMD_CONFIG  = 8'h03;
	localparam logic [7:0] TSM_CMD_ONESHOT = 8'h0f;

	// sensor_configuration fields
	localparam int         TSM_CFG_MASK_BIT  = 7;
	localparam int         TSM_CFG_STBY_BIT  = 6;
	localparam logic [7:0] TSM_CFG_RESET     = 8'h00;
	localparam logic [7:0] TSM_CFG_WR_MASK   = 8'hc0;

	// conversion timing
	localparam int TSM_CLK_PERIOD_NS = 5;
	localparam int TSM_CONV_TIME_NS  = 10000;
	localparam int TSM_CONV_CYCLES   = TSM_CONV_TIME_NS / TSM_CLK_PERIOD_NS;

	typedef struct packed {
		logic signed [7:0] remote;
		logic signed [7:0] local_die;
	} tsm_temps_t;

	typedef struct packed {
		logic signed [7:0] upper;
		logic signed [7:0] lower;
	} tsm_limits_t;

	typedef struct packed {
		logic out;
		logic oe;
	} tsm_pin_drv_t;

endpackage

/* File: sim/tb.sv */
// testbench for tsm_sensor: register rows, alert, standby and one-shot
// assumes tsm_smb_host as the smbus host on the far side
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [6:0] a;
		logic [7:0] d;
		logic       ok;
		logic [7:0] rb;
	} tsm_row_t;
	logic                 clock, reset, scl, sda, d_out, d_oe, a_out, a_oe, conv, ack;
	logic [7:0]           q;
	tsm_pkg::tsm_temps_t  raw, temps;
	tsm_pkg::tsm_limits_t lim;
	int                   fail_count, n_tests;
	tsm_row_t             rows [4] = '{'{7'h4e, 8'hff, 1'b1, 8'hc0}, '{7'h4f, 8'h00, 1'b0, 8'hc0},
		'{7'h4e, 8'h80, 1'b1, 8'h80}, '{7'h4e, 8'h3f, 1'b1, 8'h00}};
	tsm_sensor i_dut (.clock(clock), .reset(reset), .smb_clk(scl), .smb_data(sda),
		.smb_data_val(d_out), .smb_data_oe(d_oe), .alert_n_val(a_out), .alert_n_oe(a_oe),
		.raw_temps(raw), .limits(lim), .temps(temps), .converting(conv));
	tsm_smb_host i_host (.clock(clock), .dev_oe(d_oe), .scl(scl), .sda(sda));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input bit n,
		input logic [7:0] d, output logic ok);
		logic a1, a2, a3;
		i_host.start();
		i_host.xfer({a, 1'b0}, q, a1);
		i_host.xfer(c, q, a2);
		a3 = 1'b1;
		if (n)
			i_host.xfer(d, q, a3);
		i_host.stop();
		ok = a1 & a2 & a3;
	endtask
	task automatic rd(output logic [7:0] d);
		logic a;
		i_host.start();
		i_host.xfer({tsm_pkg::TSM_SMB_ADDR, 1'b0}, q, a);
		i_host.xfer(tsm_pkg::TSM_CMD_CONFIG, q, a);
		i_host.start();
		i_host.xfer({tsm_pkg::TSM_SMB_ADDR, 1'b1}, q, a);
		i_host.xfer(8'hff, d, a);
		i_host.stop();
	endtask
	// bounded wait: 0 idle, 1 converting, 2 result equals the adc words
	task automatic wait_on(input int w);
		for (int i = 0; i < 5000; i++) begin
			@(posedge clock);
			#1;
			if ((w == 0 && conv === 1'b0) || (w == 1 && conv === 1'b1) || (w == 2 && temps === raw))
				return;
		end
		fail_count++;
		$display("[FAIL] %0t wait timed out", $time);
		results();
	endtask
	task automatic set_cfg(input logic [7:0] v);
		wr(tsm_pkg::TSM_SMB_ADDR, tsm_pkg::TSM_CMD_CONFIG, 1'b1, v, ack);
		repeat (2) @(posedge clock);
		#1;
	endtask
	// reset held three cycles; used at start and again at the end
	task automatic reset_check();
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		check({11'h000, d_out, a_oe, d_oe, a_out, conv}, 16'h0001);
		check(temps, 16'h0000);
		rd(q);
		check({8'h00, q}, {8'h00, tsm_pkg::TSM_CFG_RESET});
		$display("reset test done");
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		raw <= 16'h3c14;
		lim <= 16'h32f6;
		fail_count = 0;
		n_tests = 0;
		reset_check();
		foreach (rows[i]) begin
			wr(rows[i].a, tsm_pkg::TSM_CMD_CONFIG, 1'b1, rows[i].d, ack);
			check({15'h0000, ack}, {15'h0000, rows[i].ok});
			rd(q);
			check({8'h00, q}, {8'h00, rows[i].rb});
		end
		$display("register rows done");
		// remote 60 above upper 50 in auto mode
		wait_on(2);
		repeat (2) @(posedge clock);
		#1;
		check({15'h0000, a_oe}, 16'h0001);
		set_cfg(8'h80);
		check({15'h0000, a_oe}, 16'h0000);
		set_cfg(8'h00);
		check({15'h0000, a_oe}, 16'h0001);
		@(posedge clock);
		raw <= 16'h1414;
		wait_on(2);
		repeat (2) @(posedge clock);
		#1;
		check({15'h0000, a_oe}, 16'h0000);
		// local -16 below lower -10
		@(posedge clock);
		raw <= 16'h14f0;
		wait_on(2);
		repeat (2) @(posedge clock);
		#1;
		check({15'h0000, a_oe}, 16'h0001);
		$display("alert test done");
		// standby entered while a conversion is running
		set_cfg(8'h40);
		check({15'h0000, conv}, 16'h0000);
		@(posedge clock);
		raw <= 16'h0a05;
		repeat (2100) @(posedge clock);
		#1;
		check(temps, 16'h14f0);
		// one-shot issued only in standby
		wr(tsm_pkg::TSM_SMB_ADDR, tsm_pkg::TSM_CMD_ONESHOT, 1'b0, 8'h00, ack);
		check({14'h0000, ack, conv}, 16'h0003);
		wait_on(0);
		check(temps, 16'h0a05);
		repeat (2100) @(posedge clock);
		#1;
		check({15'h0000, conv}, 16'h0000);
		$display("standby test done");
		// standby set before this reset must be cleared by it
		@(posedge clock);
		reset_check();
		results();
	end
endmodule

/* File: sim/tsm_smb_host.sv */
// smbus host model: start, stop and byte transfers on the wired-and data line
// assumes pull-ups on both lines and a device pulling data low via dev_oe
module tsm_smb_host (
	input  wire logic clock,
	input  wire logic dev_oe,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sda_h;
	// a released line reads high through its pull-up
	assign sda = sda_h & ~dev_oe;
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// clock moves first, data one cycle later, so a data change never meets a clock change
	task automatic step(input logic c, input logic d);
		@(posedge clock);
		scl <= c;
		@(posedge clock);
		sda_h <= d;
		repeat (3) @(posedge clock);
	endtask
	task automatic start();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	// msb first; ninth bit released so the device can acknowledge
	task automatic xfer(input logic [7:0] b, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
			q[i] = sda;
		end
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		ack = ~sda;
	endtask
endmodule
